// [hdl/scan_pkg.sv]
package scan_pkg;
	// Register byte offsets on the Avalon-MM slave.
	// The list window sits at 0x40 so that all sixteen entries get a word of their own.
	localparam logic [6:0] CTRL_OFS = 7'h00;
	localparam logic [6:0] COUNT_OFS = 7'h04;
	localparam logic [6:0] STAT_OFS = 7'h08;
	localparam logic [6:0] DONE_OFS = 7'h0c;
	localparam logic [6:0] PACE_OFS = 7'h10;
	localparam logic [6:0] SAMPLE_OFS = 7'h14;
	localparam logic [6:0] LIST_OFS = 7'h40;
	// Control register field positions.
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_ABORT_BIT = 1;
	localparam int CTRL_EXTPACE_BIT = 2;
	localparam int CTRL_SYNCIN_BIT = 3;
	localparam int CTRL_GATED_BIT = 4;
	localparam int CTRL_DIFF_BIT = 5;
	localparam int CTRL_TRIGEN_BIT = 6;
	localparam int CTRL_TRIGFALL_BIT = 7;
	localparam int LIST_LEN_LSB = 8;
	// Scan list geometry.
	localparam int LIST_DEPTH = 16;
	localparam int CHAN_W = 3;
	localparam int RANGE_W = 3;
	localparam int CODE_W = 14;
	// Reset values.
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [15:0] PACE_RST = 16'h01a1;
	// Pacer limit: 48 kS/s aggregate at a 20 MHz clock.
	localparam int CLK_HZ = 20000000;
	localparam int MAX_RATE_HZ = 48000;
	localparam logic [15:0] MIN_PACE_CYC = 16'((CLK_HZ + MAX_RATE_HZ - 1) / MAX_RATE_HZ);
	// Gain codes per range selector: 1,2,4,5,8,10,16,20.
	localparam logic [4:0] GAIN_SE = 5'h02;
	// Full-scale codes.
	localparam logic [13:0] FS_DIFF = 14'h3fff;
	localparam logic [13:0] FS_SE = 14'h1fff;
	// Settling delay between applying channel/gain and starting a conversion.
	localparam logic [3:0] SETTLE_CYC = 4'h8;

	// One scan list entry.
	typedef struct packed {
		logic [RANGE_W-1:0] range;
		logic [CHAN_W-1:0] chan;
	} entry_t;

	// Front-end setting handed to the multiplexer and amplifier.
	typedef struct packed {
		logic [CHAN_W-1:0] chan;
		logic [4:0] gain;
		logic diff;
	} front_t;
endpackage : scan_pkg

// [hdl/sync_edge.sv]
`timescale 1ns/10ps
`default_nettype none
// Two-stage synchroniser with rising and falling edge pulses.
module sync_edge
	import scan_pkg::*;
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic pin_in,
	output logic rise_out,
	output logic fall_out
);
	logic meta_r;
	logic sync_r;
	logic last_r;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
		end else begin
			meta_r <= pin_in;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	// Edge pulses last one cycle.
	assign rise_out = sync_r & ~last_r;
	assign fall_out = ~sync_r & last_r;
endmodule : sync_edge
`default_nettype wire

// [hdl/adc_scan_sequencer.sv]
`timescale 1ns/10ps
`default_nettype none
module adc_scan_sequencer
	import scan_pkg::*;
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [6:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic external_trigger_input,
	input wire logic sync_in,
	output logic sync_out,
	output logic sync_oe_n_out,
	output var front_t front_out,
	output logic conv_start_out,
	input wire logic conv_done_in,
	input wire logic conv_over_in,
	input wire logic [CODE_W-1:0] conv_code_in,
	output logic [CODE_W-1:0] sample_out,
	output logic sample_valid_out,
	output logic busy_out
);
	typedef enum {IDLE, WAIT_PACE, SETTLE, CONVERT} state_t;

	entry_t list_mem [LIST_DEPTH];
	logic [31:0] ctrl_r;
	logic [31:0] count_r;
	logic [31:0] done_r;
	logic [15:0] pace_r;
	logic [15:0] pace_cnt_r;
	logic pacer_clk_r;
	logic pace_tick;
	logic [3:0] idx_r;
	logic [3:0] settle_r;
	logic skip_r;
	logic ack_r;
	logic ext_rise;
	logic trig_rise;
	logic trig_fall;
	logic trig_hit;
	logic req;
	logic start_cmd;
	logic [3:0] last_idx;
	logic [4:0] gain_nxt;
	logic [CODE_W-1:0] code_nxt;
	entry_t cur;
	state_t state_r;

	assign last_idx = ctrl_r[LIST_LEN_LSB +: 4];
	assign cur = list_mem[idx_r];

	// Bus accepts each request one cycle after it appears.
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (avs_read | avs_write) & ~ack_r;
		end
	end

	// Control, count and pacing registers.
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctrl_r <= CTRL_RST;
			count_r <= 32'h0000_0000;
			pace_r <= PACE_RST;
		end else begin
			ctrl_r[CTRL_START_BIT] <= 1'b0;
			ctrl_r[CTRL_ABORT_BIT] <= 1'b0;
			if (avs_write && ack_r) begin
				case (avs_address)
					CTRL_OFS: ctrl_r <= avs_writedata & 32'h0000_0fff;
					COUNT_OFS: count_r <= avs_writedata;
					PACE_OFS: begin
						// Never faster than the sustainable aggregate rate.
						pace_r <= (avs_writedata[15:0] < MIN_PACE_CYC) ? MIN_PACE_CYC : avs_writedata[15:0];
					end
					default: ;
				endcase
			end
		end
	end

	// Scan list storage, writable only while no scan runs.
	always_ff @(posedge clk_in) begin
		if (avs_write && ack_r && avs_address[6] && state_r == IDLE) begin
			list_mem[avs_address[5:2]] <= avs_writedata[CHAN_W+RANGE_W-1:0];
		end
	end

	// Read mux; unmapped addresses read zero.
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && !ack_r) begin
			case (avs_address)
				CTRL_OFS: avs_readdata <= ctrl_r;
				COUNT_OFS: avs_readdata <= count_r;
				STAT_OFS: avs_readdata <= {26'h0, idx_r, skip_r, busy_out};
				DONE_OFS: avs_readdata <= done_r;
				PACE_OFS: avs_readdata <= {16'h0, pace_r};
				SAMPLE_OFS: avs_readdata <= {18'h0, sample_out};
				default: avs_readdata <= avs_address[6] ? {26'h0, list_mem[avs_address[5:2]]} : 32'h0000_0000;
			endcase
		end
	end

	// Internal pacer, free running; its square wave drives the sync pin.
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pace_cnt_r <= 16'h0000;
			pacer_clk_r <= 1'b0;
		end else if (pace_cnt_r >= pace_r - 16'h0001) begin
			pace_cnt_r <= 16'h0000;
			pacer_clk_r <= 1'b1;
		end else begin
			pace_cnt_r <= pace_cnt_r + 16'h0001;
			if (pace_cnt_r == (pace_r >> 1)) begin
				pacer_clk_r <= 1'b0;
			end
		end
	end
	assign pace_tick = (pace_cnt_r >= pace_r - 16'h0001);

	// Sync pin direction: output unless software selects input.
	assign sync_oe_n_out = ctrl_r[CTRL_SYNCIN_BIT];
	assign sync_out = pacer_clk_r;

	sync_edge u_sync (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.pin_in(sync_in),
		.rise_out(ext_rise),
		.fall_out()
	);
	sync_edge u_trig (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.pin_in(external_trigger_input),
		.rise_out(trig_rise),
		.fall_out(trig_fall)
	);

	// Trigger edge selection.
	assign trig_hit = ctrl_r[CTRL_TRIGFALL_BIT] ? trig_fall : trig_rise;
	assign start_cmd = ctrl_r[CTRL_TRIGEN_BIT] ? trig_hit : ctrl_r[CTRL_START_BIT];

	// Conversion request: external edges only when the pin is an input.
	assign req = (ctrl_r[CTRL_EXTPACE_BIT] && ctrl_r[CTRL_SYNCIN_BIT]) ? ext_rise :
		(ctrl_r[CTRL_EXTPACE_BIT] ? 1'b0 : pace_tick);

	// Gain table and channel limit.
	always_comb begin
		front_t f;
		f = '0;
		f.diff = ctrl_r[CTRL_DIFF_BIT];
		f.chan = ctrl_r[CTRL_DIFF_BIT] ? {1'b0, cur.chan[1:0]} : cur.chan;
		case (cur.range)
			3'h0: gain_nxt = 5'h01;
			3'h1: gain_nxt = 5'h02;
			3'h2: gain_nxt = 5'h04;
			3'h3: gain_nxt = 5'h05;
			3'h4: gain_nxt = 5'h08;
			3'h5: gain_nxt = 5'h0a;
			3'h6: gain_nxt = 5'h10;
			default: gain_nxt = 5'h14;
		endcase
		f.gain = ctrl_r[CTRL_DIFF_BIT] ? gain_nxt : GAIN_SE;
		front_out = f;
	end

	// Result clamp and width.
	always_comb begin
		if (ctrl_r[CTRL_DIFF_BIT]) begin
			code_nxt = conv_over_in ? FS_DIFF : conv_code_in;
		end else begin
			code_nxt = conv_over_in ? FS_SE : {1'b0, conv_code_in[12:0]};
		end
	end

	// Sequencer.
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_r <= IDLE;
			idx_r <= 4'h0;
			done_r <= 32'h0000_0000;
			settle_r <= 4'h0;
			skip_r <= 1'b0;
			conv_start_out <= 1'b0;
			sample_out <= '0;
			sample_valid_out <= 1'b0;
		end else begin
			conv_start_out <= 1'b0;
			sample_valid_out <= 1'b0;
			if (ctrl_r[CTRL_ABORT_BIT]) begin
				state_r <= IDLE;
			end else begin
				case (state_r)
					IDLE: begin
						if (start_cmd && count_r != 32'h0) begin
							idx_r <= 4'h0;
							done_r <= 32'h0000_0000;
							// First external pulse is dropped only in continuous mode.
							skip_r <= ctrl_r[CTRL_EXTPACE_BIT] & ~ctrl_r[CTRL_GATED_BIT];
							state_r <= WAIT_PACE;
						end
					end
					WAIT_PACE: begin
						if (req) begin
							if (skip_r) begin
								skip_r <= 1'b0;
							end else begin
								settle_r <= SETTLE_CYC;
								state_r <= SETTLE;
							end
						end
					end
					SETTLE: begin
						// Front end already shows this entry; wait for it to settle.
						if (settle_r == 4'h0) begin
							conv_start_out <= 1'b1;
							state_r <= CONVERT;
						end else begin
							settle_r <= settle_r - 4'h1;
						end
					end
					CONVERT: begin
						if (conv_done_in) begin
							sample_out <= code_nxt;
							sample_valid_out <= 1'b1;
							done_r <= done_r + 32'h1;
							idx_r <= (idx_r >= last_idx) ? 4'h0 : idx_r + 4'h1;
							state_r <= (done_r + 32'h1 >= count_r) ? IDLE : WAIT_PACE;
						end
					end
					default: state_r <= IDLE;
				endcase
			end
		end
	end
	assign busy_out = (state_r != IDLE);

	wrap_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(state_r == CONVERT && conv_done_in && idx_r >= last_idx && !ctrl_r[CTRL_ABORT_BIT]) |=> idx_r == 4'h0)
		else $error("list did not wrap");
	stop_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(state_r == CONVERT && conv_done_in && done_r + 32'h1 >= count_r && !ctrl_r[CTRL_ABORT_BIT]) |=> !busy_out) else $error("scan kept running");
	clamp_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(state_r == CONVERT && conv_done_in && conv_over_in && ctrl_r[CTRL_DIFF_BIT] && !ctrl_r[CTRL_ABORT_BIT]) |=> sample_out == FS_DIFF) else $error("no full scale");
	se_width_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		sample_valid_out && !ctrl_r[CTRL_DIFF_BIT] |-> sample_out[13] == 1'b0) else $error("single-ended too wide");
	se_gain_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		!ctrl_r[CTRL_DIFF_BIT] |-> front_out.gain == GAIN_SE) else $error("single-ended gain wrong");
	pin_dir_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		!ctrl_r[CTRL_SYNCIN_BIT] |-> !sync_oe_n_out && sync_out == pacer_clk_r) else $error("sync not driven");
	skip_first_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(state_r == WAIT_PACE && skip_r && req && !ctrl_r[CTRL_ABORT_BIT]) |=> state_r == WAIT_PACE) else $error("first pulse used");
	setup_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		conv_start_out |-> $stable(front_out) && $past(state_r) == SETTLE) else $error("start before setup");
	rate_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		pace_r >= MIN_PACE_CYC) else $error("pacer too fast");
	start_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(state_r == IDLE && start_cmd && count_r != 32'h0 && !ctrl_r[CTRL_ABORT_BIT]) |=> idx_r == 4'h0 && busy_out) else $error("scan did not start at zero");
	// Start, pacing and first-pulse handling for the trigger and the external clock.
	trig_start_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(state_r == IDLE && ctrl_r[CTRL_TRIGEN_BIT] && trig_hit && count_r != 32'h0 && !ctrl_r[CTRL_ABORT_BIT]) |=> busy_out)
		else $error("trigger edge did not start a scan");
	ext_req_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(state_r == WAIT_PACE && !skip_r && ctrl_r[CTRL_EXTPACE_BIT] && ctrl_r[CTRL_SYNCIN_BIT] && ext_rise
		&& !ctrl_r[CTRL_ABORT_BIT]) |=> state_r == SETTLE) else $error("external edge not taken");
	no_skip_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(state_r == IDLE && start_cmd && count_r != 32'h0 && !ctrl_r[CTRL_ABORT_BIT]
		&& (ctrl_r[CTRL_GATED_BIT] || !ctrl_r[CTRL_EXTPACE_BIT])) |=> !skip_r) else $error("pulse dropped");

	scan_c: cover property (@(posedge clk_in) disable iff (!rstn_in) busy_out ##1 !busy_out);
	wrap_c: cover property (@(posedge clk_in) disable iff (!rstn_in) sample_valid_out && idx_r == 4'h0 && done_r > 32'h1);
	ext_c: cover property (@(posedge clk_in) disable iff (!rstn_in) conv_start_out && ctrl_r[CTRL_EXTPACE_BIT]);
endmodule : adc_scan_sequencer
`default_nettype wire

// [tb/conv_model.sv]
`timescale 1ns/10ps
`default_nettype none
// Converter model: answers each start pulse after four cycles and echoes the front-end setting.
module conv_model
	import scan_pkg::*;
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic start_in,
	input wire front_t front_in,
	input wire logic over_mode_in,
	output logic done_out,
	output logic over_out,
	output logic [CODE_W-1:0] code_out
);
	logic [2:0] wait_r;
	logic [CODE_W-1:0] code_r;
	// The setting is captured at start, so a change of the front end after start does not show up in the code.
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wait_r <= 3'h0;
			code_r <= '0;
		end else if (start_in) begin
			wait_r <= 3'h4;
			code_r <= {5'h00, front_in.gain, front_in.diff, front_in.chan};
		end else if (wait_r != 3'h0) begin
			wait_r <= wait_r - 3'h1;
		end
	end
	// Outside the done cycle the code bus shows the inverse, never a held value.
	assign done_out = (wait_r == 3'h1);
	assign over_out = done_out & over_mode_in;
	assign code_out = done_out ? code_r : ~code_r;
endmodule : conv_model
`default_nettype wire

// [tb/adc_scan_sequencer_bench.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module adc_scan_sequencer_bench
	import scan_pkg::*;
;
	logic clk_in = 1'b0, rstn_in = 1'b0, rd = 1'b0, wr = 1'b0, ext_clk = 1'b0, over_mode = 1'b0, trig = 1'b0;
	logic [6:0] addr = 7'h00;
	logic [31:0] wdata = 32'h0, rdata, q;
	logic waitreq, sync_in, sync_out, sync_oe_n, conv_start, done, over, sample_valid, busy, prev;
	logic [CODE_W-1:0] code, sample;
	front_t front;
	int fails = 0, check_count = 0, cycles = 0, sync_rises = 0;
	logic [CODE_W-1:0] got[$];
	logic [4:0] gains[8] = '{5'h01, 5'h02, 5'h04, 5'h05, 5'h08, 5'h0a, 5'h10, 5'h14};
	logic [2:0] chans[3] = '{3'h3, 3'h1, 3'h2};
	logic [2:0] ranges[3] = '{3'h0, 3'h5, 3'h7};
	// The other unit's clock reaches the pin only while the device has let it go.
	assign sync_in = sync_oe_n ? ext_clk : sync_out;
	always #25 clk_in = ~clk_in;
	adc_scan_sequencer DUT (.clk_in(clk_in), .rstn_in(rstn_in), .avs_address(addr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(waitreq),
		.external_trigger_input(trig), .sync_in(sync_in), .sync_out(sync_out), .sync_oe_n_out(sync_oe_n),
		.front_out(front), .conv_start_out(conv_start), .conv_done_in(done), .conv_over_in(over),
		.conv_code_in(code), .sample_out(sample), .sample_valid_out(sample_valid), .busy_out(busy));
	conv_model conv (.clk_in(clk_in), .rstn_in(rstn_in), .start_in(conv_start), .front_in(front),
		.over_mode_in(over_mode), .done_out(done), .over_out(over), .code_out(code));
	// Collects samples, counts pacer edges on the pin and cuts a hang short.
	always @(posedge clk_in) begin
		cycles++;
		if (sample_valid === 1'b1) got.push_back(sample);
		if (sync_out === 1'b1 && prev === 1'b0) sync_rises++;
		prev = sync_out;
		if (cycles == 20000) begin
			fails++;
			give_verdict();
		end
	end
	// One bus cycle held until waitrequest is seen low.
	task bus(input logic w, input logic [6:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		do @(posedge clk_in); while (waitreq !== 1'b0);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus
	task run_idle;
		repeat (2) @(posedge clk_in);
		while (busy !== 1'b0) @(posedge clk_in);
		// The last sample is collected at the edge where busy is first seen low.
		@(posedge clk_in);
	endtask : run_idle
	// One pulse of the external clock, spaced for at most 48 kHz.
	task pulse;
		@(posedge clk_in);
		ext_clk <= 1'b1;
		repeat (20) @(posedge clk_in);
		ext_clk <= 1'b0;
		repeat (400) @(posedge clk_in);
	endtask : pulse
	task t_reset;
		`CHK(sync_oe_n, 1'b0)
		`CHK(busy, 1'b0)
		bus(1'b0, CTRL_OFS, 32'h0);
		`CHK(q, CTRL_RST)
		bus(1'b0, PACE_OFS, 32'h0);
		`CHK(q[15:0], PACE_RST)
		bus(1'b0, 7'h18, 32'h0);
		`CHK(q, 32'h0)
		bus(1'b1, LIST_OFS + 7'h3c, 32'h2d);
		bus(1'b0, LIST_OFS + 7'h3c, 32'h0);
		`CHK(q, 32'h2d)
	endtask : t_reset
	// Three-entry differential list, seven samples, gated bit set on an internally paced scan.
	task t_internal;
		for (int i = 0; i < 3; i++) bus(1'b1, LIST_OFS + 7'(4 * i), {26'h0, ranges[i], chans[i]});
		bus(1'b1, COUNT_OFS, 32'h7);
		bus(1'b1, PACE_OFS, {16'h0, MIN_PACE_CYC});
		got.delete();
		bus(1'b1, CTRL_OFS, 32'h231);
		run_idle();
		`CHK(got.size(), 7)
		for (int i = 0; i < 7; i++) `CHK(got[i], {5'h00, gains[ranges[i % 3]], 1'b1, chans[i % 3]})
		`CHK(sync_rises > 0, 1'b1)
		bus(1'b0, DONE_OFS, 32'h0);
		`CHK(q, 32'h7)
		bus(1'b0, STAT_OFS, 32'h0);
		`CHK(q, 32'h4)
		bus(1'b0, SAMPLE_OFS, 32'h0);
		`CHK(q, {18'h0, 5'h00, gains[ranges[0]], 1'b1, chans[0]})
	endtask : t_internal
	// Single sample with the given control bits and overrange state.
	task one_sample(input logic [31:0] c, input logic ov, input logic [CODE_W-1:0] exp);
		over_mode = ov;
		got.delete();
		bus(1'b1, COUNT_OFS, 32'h1);
		bus(1'b1, CTRL_OFS, c | 32'h1);
		run_idle();
		`CHK(got.size(), 1)
		`CHK(got[0], exp)
	endtask : one_sample
	task t_modes;
		bus(1'b1, LIST_OFS, 32'h5);
		one_sample(32'h0, 1'b0, {5'h00, GAIN_SE, 1'b0, 3'h5});
		one_sample(32'h0, 1'b1, FS_SE);
		bus(1'b1, LIST_OFS, 32'h3a);
		one_sample(32'h20, 1'b1, FS_DIFF);
		over_mode = 1'b0;
	endtask : t_modes
	// External pacing, continuous then gated, two samples each.
	task t_external;
		got.delete();
		bus(1'b1, COUNT_OFS, 32'h2);
		// Turn the pin around first so that no pacer edge left in the synchroniser counts as a pulse.
		bus(1'b1, CTRL_OFS, 32'h2c);
		bus(1'b1, CTRL_OFS, 32'h2d);
		repeat (2) pulse();
		`CHK(sync_oe_n, 1'b1)
		`CHK(got.size(), 1)
		`CHK(busy, 1'b1)
		pulse();
		run_idle();
		`CHK(got.size(), 2)
		`CHK(got[0], {5'h00, 5'h14, 1'b1, 3'h2})
		got.delete();
		bus(1'b1, CTRL_OFS, 32'h3d);
		repeat (2) pulse();
		run_idle();
		`CHK(got.size(), 2)
	endtask : t_external
	// Trigger edges start scans, the list stays frozen while one runs, and abort ends a scan at once.
	task t_trigger;
		bus(1'b1, COUNT_OFS, 32'h3);
		bus(1'b1, CTRL_OFS, 32'h40);
		got.delete();
		trig <= 1'b1;
		repeat (5) @(posedge clk_in);
		`CHK(busy, 1'b1)
		bus(1'b1, LIST_OFS, 32'h3f);
		bus(1'b0, LIST_OFS, 32'h0);
		`CHK(q, 32'h3a)
		run_idle();
		`CHK(got.size(), 3)
		`CHK(got[0], {5'h00, GAIN_SE, 1'b0, 3'h2})
		bus(1'b1, CTRL_OFS, 32'hc0);
		got.delete();
		trig <= 1'b0;
		repeat (5) @(posedge clk_in);
		`CHK(busy, 1'b1)
		run_idle();
		`CHK(got.size(), 3)
		trig <= 1'b1;
		repeat (6) @(posedge clk_in);
		`CHK(busy, 1'b0)
		bus(1'b1, COUNT_OFS, 32'h5);
		bus(1'b1, CTRL_OFS, 32'h1);
		repeat (2) @(posedge clk_in);
		`CHK(busy, 1'b1)
		bus(1'b1, CTRL_OFS, 32'h2);
		repeat (2) @(posedge clk_in);
		`CHK(busy, 1'b0)
		trig <= 1'b0;
	endtask : t_trigger
	task give_verdict;
		$display("Mismatches %0d, comparisons %0d", fails, check_count);
		if (fails == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : give_verdict
	// Reset for three cycles, then the scenarios in turn.
	initial begin
		repeat (3) @(posedge clk_in);
		rstn_in <= 1'b1;
		@(posedge clk_in);
		t_reset();
		t_internal();
		t_modes();
		t_external();
		t_trigger();
		give_verdict();
	end
endmodule : adc_scan_sequencer_bench
`default_nettype wire
